// ===== hdl/ssc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module spread_spectrum_clock_sequencer
   import ssc_pkg::*;
#(
   parameter bit QUADRATURE = 1'b0,
   parameter int MASTER_CYCLES = `SSC_MASTER_CYCLES
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_rate_select_pin_hi,
   input wire logic i_rate_select_pin_lo,
   output logic o_phase_a_output,
   output logic o_phase_b_output,
   output logic [6:0] o_step_dac,
   output logic o_spread_modulation_on
);
   localparam logic signed [15:0] MC_S = 16'(MASTER_CYCLES);
   localparam logic signed [15:0] DEN_S = 16'(`SSC_SPREAD_DEN);

   ssc_core_st_t st_q;
   ssc_core_st_t st_d;
   ssc_lfsr_if #(.W(`SSC_LFSR_WIDTH)) lf ();

   ssc_lfsr u_lfsr (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .lf(lf.gen)
   );

   function automatic logic [6:0] rate_n(input ssc_rate_t r);
      unique case (r)
         SSC_RATE_16: rate_n = 7'(`SSC_N_LOW);
         SSC_RATE_32: rate_n = 7'(`SSC_N_FLOAT);
         SSC_RATE_64: rate_n = 7'(`SSC_N_HIGH);
         default: rate_n = 7'(`SSC_N_FLOAT);
      endcase
   endfunction

   logic signed [15:0] code_s;
   logic signed [15:0] off_s;
   logic signed [15:0] per_s;
   logic tick;
   logic rise;
   logic boundary;
   logic loop_seen;
   logic [6:0] nval;

   always_comb
   begin
      st_d = st_q;
      nval = rate_n(st_q.rate);
      // DAC code above midscale raises the master current, so shortens the period
      code_s = $signed({9'h000, st_q.dac}) - $signed({9'h000, `SSC_DAC_MID});
      off_s = (code_s * MC_S) / DEN_S;
      per_s = MC_S - off_s;
      tick = (st_q.cnt == 8'h00);
      rise = tick && !st_q.a;
      boundary = rise && (st_q.ocnt == nval - 7'h01);
      // A looped-back output gives about one rising edge per output cycle
      loop_seen = ({1'b0, st_q.edges} >= {3'b000, nval[6:1]})
         && ({1'b0, st_q.edges} <= {1'b0, nval, 1'b0});
      st_d.step = 1'b0;
      st_d.pin_prev = i_rate_select_pin_hi;
      if (i_rate_select_pin_hi && !st_q.pin_prev && st_q.edges != 8'hff)
      begin
         st_d.edges = st_q.edges + 8'h01;
      end
      if (tick)
      begin
         st_d.a = !st_q.a;
         st_d.cnt = 8'(per_s - 16'sd1);
         st_d.per = per_s[7:0];
      end
      else
      begin
         st_d.cnt = st_q.cnt - 8'h01;
      end
      if (QUADRATURE)
      begin
         if (st_q.cnt == {1'b0, st_q.per[7:1]})
         begin
            st_d.b = !st_q.b;
         end
      end
      else
      begin
         st_d.b = !st_d.a;
      end
      if (rise && st_q.muted)
      begin
         // Released on the rise after the count is full, so 64 whole cycles stay silent
         if (st_q.mute == 7'(`SSC_MUTE_CYCLES))
         begin
            st_d.muted = 1'b0;
         end
         else
         begin
            st_d.mute = st_q.mute + 7'h01;
         end
      end
      if (rise)
      begin
         st_d.ocnt = st_q.ocnt + 7'h01;
      end
      if (boundary)
      begin
         // Pin level and loopback are only looked at here, so the DAC never glitches mid-step
         st_d.ocnt = 7'h00;
         st_d.step = 1'b1;
         st_d.edges = 8'h00;
         st_d.dis = loop_seen;
         if (i_rate_select_pin_lo)
         begin
            st_d.rate = SSC_RATE_16;
         end
         else if (i_rate_select_pin_hi)
         begin
            st_d.rate = SSC_RATE_64;
         end
         else
         begin
            st_d.rate = SSC_RATE_32;
         end
         st_d.dac = loop_seen ? `SSC_DAC_MID : lf.state[6:0];
      end
      st_d.out_a = st_d.muted ? 1'b0 : st_d.a;
      st_d.out_b = st_d.muted ? 1'b0 : st_d.b;
      st_d.spread_on = !st_d.dis;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q <= '{cnt: 8'h00, per: 8'(MASTER_CYCLES), a: 1'b0, b: 1'b0, muted: 1'b1,
                   mute: 7'h00, ocnt: 7'h00, rate: SSC_RATE_32, dis: 1'b0, pin_prev: 1'b0,
                   edges: 8'h00, dac: `SSC_DAC_MID, step: 1'b0, out_a: 1'b0,
                   out_b: 1'b0, spread_on: 1'b1};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign lf.step = st_q.step;
   assign o_phase_a_output = st_q.out_a;
   assign o_phase_b_output = st_q.out_b;
   assign o_step_dac = st_q.dac;
   assign o_spread_modulation_on = st_q.spread_on;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);

   property p_half_rate;
      $changed(st_q.a) |-> $past(st_q.cnt) == 8'h00 && st_q.cnt == st_q.per - 8'h01;
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("Phase A toggled off a master tick");

   property p_duty;
      tick |=> ##1 (!$changed(st_q.a)) [*2];
   endproperty
   a_duty: assert property (p_duty) else $error("Half period shorter than three cycles");

   property p_compl;
      !QUADRATURE && !st_q.muted |-> st_q.out_b == !st_q.out_a;
   endproperty
   a_compl: assert property (p_compl) else $error("Complementary outputs not opposite");

   property p_quad;
      QUADRATURE && $changed(st_q.b) |-> $past(st_q.cnt) == {1'b0, $past(st_q.per[7:1])};
   endproperty
   a_quad: assert property (p_quad) else $error("Quadrature output off its quarter point");

   property p_mute;
      st_q.muted |-> !o_phase_a_output && !o_phase_b_output && st_q.mute <= 7'd64;
   endproperty
   a_mute: assert property (p_mute) else $error("Output seen while muted");

   property p_unmute;
      $fell(st_q.muted) |-> $past(st_q.mute) == 7'd64 && st_q.mute == 7'd64 && $rose(st_q.a);
   endproperty
   a_unmute: assert property (p_unmute) else $error("Mute released at wrong count");

   property p_dac_step;
      $changed(st_q.dac) |-> ##1 $past(st_q.step);
   endproperty
   a_dac_step: assert property (p_dac_step) else $error("DAC moved off a shift boundary");

   property p_step_n;
      st_q.step |-> $past(st_q.ocnt) == rate_n($past(st_q.rate)) - 7'h01 && st_q.ocnt == 7'h00;
   endproperty
   a_step_n: assert property (p_step_n) else $error("Shift not after N output cycles");

   property p_rate_lo;
      boundary && i_rate_select_pin_lo |=> st_q.rate == SSC_RATE_16;
   endproperty
   a_rate_lo: assert property (p_rate_lo) else $error("Low pin did not pick N of 16");

   property p_rate_dis;
      st_q.step && st_q.dis |-> st_q.dac == `SSC_DAC_MID;
   endproperty
   a_rate_dis: assert property (p_rate_dis) else $error("Disabled modulation not at midscale");

   property p_loop;
      boundary && loop_seen |=> st_q.dis;
   endproperty
   a_loop: assert property (p_loop) else $error("Loopback did not stop modulation");

   property p_spread;
      tick |=> (16'(st_q.per) * 16'sd10 >= MC_S * 16'(`SSC_SPREAD_LO_TENTHS))
         && (16'(st_q.per) * 16'sd10 <= MC_S * 16'(`SSC_SPREAD_HI_TENTHS));
   endproperty
   a_spread: assert property (p_spread) else $error("Period outside the spread band");

   c_unmute: cover property ($fell(st_q.muted));
   c_step: cover property (st_q.step && !st_q.dis);
   c_disable: cover property ($rose(st_q.dis));
   c_rate64: cover property (st_q.rate == SSC_RATE_64 && st_q.step);
endmodule
`default_nettype wire

// ===== hdl/ssc_map.svh
// Operation
// - Each output clock runs at half the master oscillator rate.
// - Both outputs are square waves, high for half the period.
// - Phase B lags phase A by half a period, or a quarter in quadrature.
// - Outputs stay muted for the first 64 cycles after power-up.
// - Modulation comes from a 15-bit linear feedback shift register.
// - The sequence is maximal length, repeating after 32767 shifts.
// - Seven register bits feed the step DAC, updated once per shift.
// - The shift register advances once every N output cycles.
// - Rate pin low, floating, high selects N of 16, 32, 64.
// - An output looped back to the rate pin stops modulation.
// - Spread keeps frequency within 0.9 to 1.1 of nominal; off means nominal.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_LFSR_WIDTH 15
`define SSC_LFSR_SEED 15'h0001
`define SSC_LFSR_TAP_HI 14
`define SSC_LFSR_TAP_LO 13
`define SSC_DAC_WIDTH 7
`define SSC_DAC_MID 7'h40
`define SSC_MUTE_CYCLES 64
`define SSC_N_LOW 16
`define SSC_N_FLOAT 32
`define SSC_N_HIGH 64
`define SSC_MASTER_CYCLES 40
`define SSC_SPREAD_DEN 640
`define SSC_SPREAD_LO_TENTHS 9
`define SSC_SPREAD_HI_TENTHS 11
`endif

// ===== hdl/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
   typedef enum logic [2:0] {
      SSC_RATE_16 = 3'b001,
      SSC_RATE_32 = 3'b010,
      SSC_RATE_64 = 3'b100
   } ssc_rate_t;

   typedef struct packed {
      logic [14:0] shreg;
   } ssc_lfsr_st_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] per;
      logic a;
      logic b;
      logic muted;
      logic [6:0] mute;
      logic [6:0] ocnt;
      ssc_rate_t rate;
      logic dis;
      logic pin_prev;
      logic [7:0] edges;
      logic [6:0] dac;
      logic step;
      logic out_a;
      logic out_b;
      logic spread_on;
   } ssc_core_st_t;
endpackage
`default_nettype wire

// ===== hdl/ssc_lfsr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssc_lfsr_if #(parameter int W = 15);
   logic step;
   logic [W-1:0] state;
   modport ctrl (output step, input state);
   modport gen (input step, output state);
endinterface
`default_nettype wire

// ===== hdl/ssc_lfsr.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module ssc_lfsr
   import ssc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   ssc_lfsr_if.gen lf
);
   ssc_lfsr_st_t st_q;
   ssc_lfsr_st_t st_d;

   always_comb
   begin
      st_d = st_q;
      // x^15 + x^14 + 1 is primitive, so the all-zero lock-up state is never entered
      if (lf.step)
      begin
         st_d.shreg = {st_q.shreg[`SSC_LFSR_WIDTH-2:0],
                       st_q.shreg[`SSC_LFSR_TAP_HI] ^ st_q.shreg[`SSC_LFSR_TAP_LO]};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q <= '{shreg: `SSC_LFSR_SEED};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign lf.state = st_q.shreg;

   property p_lfsr_nonzero;
      @(posedge i_core_clk) disable iff (!i_rstn) st_q.shreg != 15'h0000;
   endproperty
   a_lfsr_nonzero: assert property (p_lfsr_nonzero) else $error("Shift register hit zero");

   property p_lfsr_shift;
      @(posedge i_core_clk) disable iff (!i_rstn)
         lf.step |=> st_q.shreg[`SSC_LFSR_WIDTH-1:1] == $past(st_q.shreg[`SSC_LFSR_WIDTH-2:0])
            && st_q.shreg[0] == ($past(st_q.shreg[14]) ^ $past(st_q.shreg[13]));
   endproperty
   a_lfsr_shift: assert property (p_lfsr_shift) else $error("Shift register stepped wrong");

   property p_lfsr_hold;
      @(posedge i_core_clk) disable iff (!i_rstn) !lf.step |=> $stable(st_q.shreg);
   endproperty
   a_lfsr_hold: assert property (p_lfsr_hold) else $error("Shift register moved unasked");
endmodule
`default_nettype wire

// ===== tb/ssc_rate_drv.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_rate_drv
(
   input wire logic i_core_clk,
   input wire logic [1:0] i_mode,
   input wire logic i_loop,
   output logic o_pin_hi,
   output logic o_pin_lo
);
   // Mode 0 low, 1 floating, 2 high, 3 one output looped back to the pin
   always @(posedge i_core_clk)
   begin
      #2;
      o_pin_hi = (i_mode == 2'h2) || (i_mode == 2'h3 && i_loop);
      o_pin_lo = (i_mode == 2'h0);
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int MC = 20;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] mode = 2'h1;
   logic hi, lo, a, b, a2, b2, on;
   logic [6:0] dac;
   int n_fail = 0;
   int num_checks = 0;
   always #12.5 clk = ~clk;
   spread_spectrum_clock_sequencer #(.QUADRATURE(1'b0), .MASTER_CYCLES(MC)) dut_u (
      .i_core_clk(clk), .i_rstn(rstn), .i_rate_select_pin_hi(hi), .i_rate_select_pin_lo(lo),
      .o_phase_a_output(a), .o_phase_b_output(b), .o_step_dac(dac),
      .o_spread_modulation_on(on));
   // Quadrature twin sees the same pin, so it tracks the first instance edge for edge
   spread_spectrum_clock_sequencer #(.QUADRATURE(1'b1), .MASTER_CYCLES(MC)) dut_u2 (
      .i_core_clk(clk), .i_rstn(rstn), .i_rate_select_pin_hi(hi), .i_rate_select_pin_lo(lo),
      .o_phase_a_output(a2), .o_phase_b_output(b2), .o_step_dac(),
      .o_spread_modulation_on());
   ssc_rate_drv drv_u (.i_core_clk(clk), .i_mode(mode), .i_loop(a), .o_pin_hi(hi),
      .o_pin_lo(lo));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic [1:0] m);
      @(posedge clk);
      #2;
      rstn = 1'b0;
      mode = m;
      repeat (4) @(posedge clk);
      #2;
      rstn = 1'b1;
   endtask
   task automatic wait_a(input logic v, output int t);
      t = 0;
      do
      begin
         step();
         t++;
      end while (a !== v && t < 4000);
      if (t >= 4000)
         chk(1'b0, 1'b1);
   endtask
   task automatic t_spread(input logic [1:0] m, input int n, input int cnt);
      int t, h, r;
      logic [14:0] s;
      do_reset(m);
      wait_a(1'b1, t);
      // First 32 rises at nominal for any n, the rest of the first 65 at no less than 38 cycles each
      chk(t > 2400 && t < 2700, 1'b1);
      for (r = 65; r < 65 + cnt; r++)
      begin
         s = 15'h0001;
         repeat ((r - 32) / n) s = {s[13:0], s[14] ^ s[13]};
         chk(dac, s[6:0]);
         chk(on, 1'b1);
         chk(b, 1'b0);
         wait_a(1'b0, h);
         chk(h >= MC * 9 / 10 && h <= MC * 11 / 10, 1'b1);
         chk(b, 1'b1);
         wait_a(1'b1, t);
      end
   endtask
   task automatic t_loop();
      int t, h;
      do_reset(2'h3);
      t = 0;
      while (on !== 1'b0 && t < 20000)
      begin
         step();
         t++;
      end
      chk(on, 1'b0);
      chk(dac, 7'h40);
      repeat (4)
      begin
         wait_a(1'b0, t);
         wait_a(1'b1, t);
      end
      chk(a2, 1'b1);
      t = 0;
      while (b2 !== 1'b1 && t < 100)
      begin
         step();
         t++;
      end
      chk(t, MC - MC / 2);
      wait_a(1'b0, h);
      chk(t + h, MC);
      chk(b, 1'b1);
      wait_a(1'b1, h);
      chk(h, MC);
      chk(dac, 7'h40);
   endtask
   initial
   begin
      t_spread(2'h0, 16, 260);
      t_spread(2'h1, 32, 140);
      t_spread(2'h2, 64, 140);
      t_loop();
      test_done();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
